//--- hw/dpsf_block.sv
// dual-port memory block with embedded synchronous fifo control and a 4-word output buffer
// assumes every input comes from fabric logic on core_clk_i, including the test-port load path

module dpsf_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [WIDTH-1:0] store_next [DEPTH];
    logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready_o = (cnt_reg != FULL_CNT);
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = store_reg[rptr_reg];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        store_next = store_reg;
        if (push) begin
            store_next[wptr_reg] = in_data_i;
        end
        wptr_next = push ? ((wptr_reg == LAST_PTR) ? '0 : wptr_reg + 1'b1) : wptr_reg;
        rptr_next = pop ? ((rptr_reg == LAST_PTR) ? '0 : rptr_reg + 1'b1) : rptr_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
        end
    end

    // data words carry no reset; valid never exposes an unwritten slot
    always_ff @(posedge core_clk_i) begin
        store_reg <= store_next;
    end
endmodule

module dpsf_block (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic fifo_mode_i,
    input wire logic [2:0] wr_mode_i,
    input wire logic [2:0] rd_mode_i,
    input wire logic blk_sel_i,
    input wire logic wr_en_i,
    input wire logic [11:0] wr_addr_i,
    input wire logic [17:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [11:0] rd_addr_i,
    output logic rd_ready_o,
    output logic rd_valid_o,
    input wire logic rd_data_ready_i,
    output logic [17:0] rd_data_o,
    input wire logic [12:0] fifo_depth_i,
    input wire logic [12:0] ae_level_i,
    input wire logic [12:0] af_level_i,
    output logic empty_o,
    output logic full_o,
    output logic almost_empty_flag_o,
    output logic almost_full_flag_o,
    output logic [12:0] fill_count_o,
    input wire logic init_we_i,
    input wire logic [8:0] init_row_i,
    input wire logic [8:0] init_data_i
);
    // 512 rows of 9 bits; narrow modes use the low 8 bits of a row
    logic [8:0] mem_reg [dpsf_pkg::ROWS];
    logic [8:0] mem_next [dpsf_pkg::ROWS];
    logic [11:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [12:0] count_reg, count_next;
    logic [12:0] eff_depth, maxd;
    logic [2:0] rmode;
    logic [11:0] waddr, raddr;
    logic [8:0] wrow;
    logic [17:0] rword;
    logic push, pop, ram_wr, ram_rd, do_write, rd_take, buf_in_ready;

    // shared row decode: which 9-bit row a word address lands in
    function automatic logic [8:0] row_of(input logic [2:0] mode, input logic [11:0] addr);
        case (mode)
            3'h4: row_of = {addr[7:0], 1'b0};
            3'h3: row_of = addr[8:0];
            3'h2: row_of = addr[9:1];
            3'h1: row_of = addr[10:2];
            default: row_of = addr[11:3];
        endcase
    endfunction

    function automatic logic [17:0] rd_word(input logic [2:0] mode, input logic [11:0] addr);
        logic [8:0] r;
        r = row_of(mode, addr);
        case (mode)
            3'h4: rd_word = {mem_reg[r | 9'h001], mem_reg[r]};
            3'h3: rd_word = {9'h000, mem_reg[r]};
            3'h2: rd_word = {14'h0000, mem_reg[r][{addr[0], 2'b00} +: 4]};
            3'h1: rd_word = {16'h0000, mem_reg[r][{addr[1:0], 1'b0} +: 2]};
            default: rd_word = {17'h00000, mem_reg[r][addr[2:0]]};
        endcase
    endfunction

    always_comb begin
        maxd = dpsf_pkg::max_depth(wr_mode_i);
        // zero or oversize depth falls back to the full array for the width
        eff_depth = (fifo_depth_i == 13'h0000 || fifo_depth_i > maxd) ? maxd : fifo_depth_i;
        full_o = (count_reg >= eff_depth);
        empty_o = (count_reg == 13'h0000);
        almost_empty_flag_o = (count_reg <= ae_level_i);
        almost_full_flag_o = (count_reg >= af_level_i);
        fill_count_o = count_reg;
        rd_ready_o = buf_in_ready;
        push = fifo_mode_i && wr_en_i && !full_o;
        pop = fifo_mode_i && rd_en_i && !empty_o && buf_in_ready;
        // blk_sel_i lets address decode spread one deep memory over many blocks
        ram_wr = !fifo_mode_i && wr_en_i && blk_sel_i;
        ram_rd = !fifo_mode_i && rd_en_i && blk_sel_i && buf_in_ready;
        do_write = push || ram_wr;
        rd_take = pop || ram_rd;
        waddr = fifo_mode_i ? wptr_reg : wr_addr_i;
        raddr = fifo_mode_i ? rptr_reg : rd_addr_i;
        // fifo reads use the write organisation so words come back whole
        rmode = fifo_mode_i ? wr_mode_i : rd_mode_i;
        rword = rd_word(rmode, raddr);
    end

    always_comb begin
        mem_next = mem_reg;
        wrow = row_of(wr_mode_i, waddr);
        if (do_write) begin
            case (wr_mode_i)
                3'h4: begin
                    mem_next[wrow] = wr_data_i[8:0];
                    mem_next[wrow | 9'h001] = wr_data_i[17:9];
                end
                3'h3: mem_next[wrow] = wr_data_i[8:0];
                3'h2: mem_next[wrow][{waddr[0], 2'b00} +: 4] = wr_data_i[3:0];
                3'h1: mem_next[wrow][{waddr[1:0], 1'b0} +: 2] = wr_data_i[1:0];
                default: mem_next[wrow][waddr[2:0]] = wr_data_i[0];
            endcase
        end
        // test-port load wins over a fabric write to the same row
        if (init_we_i) begin
            mem_next[init_row_i] = init_data_i;
        end
    end

    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        count_next = count_reg;
        if (!fifo_mode_i) begin
            // leaving fifo operation flushes the queue
            wptr_next = dpsf_pkg::PTR_RESET;
            rptr_next = dpsf_pkg::PTR_RESET;
            count_next = dpsf_pkg::CNT_RESET;
        end else begin
            if (push) begin
                wptr_next = ({1'b0, wptr_reg} == eff_depth - 13'h0001) ? 12'h000 : wptr_reg + 12'h001;
            end
            if (pop) begin
                rptr_next = ({1'b0, rptr_reg} == eff_depth - 13'h0001) ? 12'h000 : rptr_reg + 12'h001;
            end
            if (push && !pop) begin
                count_next = count_reg + 13'h0001;
            end else if (pop && !push) begin
                count_next = count_reg - 13'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wptr_reg <= dpsf_pkg::PTR_RESET;
            rptr_reg <= dpsf_pkg::PTR_RESET;
            count_reg <= dpsf_pkg::CNT_RESET;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
        end
    end

    // array contents survive reset, as a memory should
    always_ff @(posedge core_clk_i) begin
        mem_reg <= mem_next;
    end

    // read words queue here; a stalled consumer stops new reads being taken
    dpsf_buf #(
        .WIDTH(dpsf_pkg::BUF_W),
        .DEPTH(dpsf_pkg::BUF_DEPTH)
    ) u_out_buf (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .in_valid_i(rd_take),
        .in_ready_o(buf_in_ready),
        .in_data_i(rword),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_data_ready_i),
        .out_data_o(rd_data_o)
    );

    a_full_blocks_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && full_o && !pop |=> count_reg == $past(count_reg) && wptr_reg == $past(wptr_reg))
        else $error("write taken while full");

    a_empty_blocks_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && empty_o |-> !rd_take ##1 rptr_reg == $past(rptr_reg))
        else $error("read taken while empty");

    a_count_step_up: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && push && !pop |=> fill_count_o == $past(fill_count_o) + 13'h0001)
        else $error("fill count did not rise on write");

    a_wptr_wraps: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && push && {1'b0, wptr_reg} == eff_depth - 13'h0001 |=> wptr_reg == 12'h000)
        else $error("write pointer did not wrap at depth");

    a_full_at_depth: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && count_reg == eff_depth - 13'h0001 && push && !pop |=> full_o && !empty_o)
        else $error("full not raised on reaching depth");

    a_empty_is_almost: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && pop && !push && count_reg == 13'h0001 |=> empty_o && almost_empty_flag_o)
        else $error("almost empty missing when drained");

    a_init_loads_row: assert property (@(posedge core_clk_i) disable iff (reset_i)
        init_we_i |=> mem_reg[$past(init_row_i)] == $past(init_data_i))
        else $error("test-port load not stored");

    a_stall_holds_reads: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !rd_ready_o |-> !rd_take)
        else $error("read taken with output buffer full");

    a_read_gives_valid: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_take |=> rd_valid_o)
        else $error("taken read produced no output word");

    a_count_step_down: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && pop && !push |=> fill_count_o == $past(fill_count_o) - 13'h0001)
        else $error("fill count did not fall on read");

    a_rptr_wraps: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && pop && {1'b0, rptr_reg} == eff_depth - 13'h0001 |=> rptr_reg == 12'h000)
        else $error("read pointer did not wrap at depth");

    a_ram_flushes_queue: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !fifo_mode_i |=> fill_count_o == 13'h0000 && wptr_reg == 12'h000 && rptr_reg == 12'h000)
        else $error("queue not flushed outside fifo operation");

    a_af_rises_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && push && !pop && count_reg + 13'h0001 == af_level_i |=> almost_full_flag_o)
        else $error("almost full missing at its threshold");

    a_ae_reached_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fifo_mode_i && pop && !push && count_reg == ae_level_i + 13'h0001 |=> almost_empty_flag_o)
        else $error("almost empty missing at its threshold");

    // a stalled consumer must see the same head word until it takes it
    a_head_held_stalled: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_valid_o && !rd_data_ready_i |=> rd_valid_o && $stable(rd_data_o))
        else $error("output word lost while consumer stalled");

    a_ram_needs_select: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !fifo_mode_i && !blk_sel_i |-> !do_write && !rd_take)
        else $error("deselected block took a ram access");
endmodule

//--- hw/dpsf_pkg.sv
// constants and helpers shared by the dual-port memory / fifo block
// assumes a single core clock; all users reference names as dpsf_pkg::name
package dpsf_pkg;
    localparam int MEM_BITS = 4608;
    localparam int ROWS = 512;
    localparam int ROW_W = 9;
    localparam int ROW_AW = 9;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 18;
    localparam int CNT_W = 13;
    localparam int BUF_W = 18;
    localparam int BUF_DEPTH = 4;
    localparam logic [12:0] CNT_RESET = 13'h0000;
    localparam logic [11:0] PTR_RESET = 12'h000;

    // port organisation codes; 3'h5..3'h7 are illegal and act as x1
    typedef enum logic [2:0] {
        DPSF_X1 = 3'h0,
        DPSF_X2 = 3'h1,
        DPSF_X4 = 3'h2,
        DPSF_X9 = 3'h3,
        DPSF_X18 = 3'h4
    } dpsf_mode_t;

    // words held by the array for one organisation
    function automatic logic [12:0] max_depth(input logic [2:0] mode);
        case (mode)
            3'h1: max_depth = 13'h0800;
            3'h2: max_depth = 13'h0400;
            3'h3: max_depth = 13'h0200;
            3'h4: max_depth = 13'h0100;
            default: max_depth = 13'h1000;
        endcase
    endfunction
endpackage

//--- test/dpsf_consumer.sv
// fabric-side consumer of the block's read-data stream
// assumes the stream is synchronous to core_clk_i; the bench stalls it on purpose
module dpsf_consumer (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [17:0] data_i,
    output logic ready_o,
    output logic [17:0] got_data_o,
    output logic [7:0] got_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ready is dropped while stalled so the output buffer can fill up
    assign ready_o = !stall_i;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            got_cnt_o <= 8'h00;
            got_data_o <= 18'h00000;
        end else if (valid_i && ready_o) begin
            got_cnt_o <= got_cnt_o + 8'h01;
            got_data_o <= data_i;
        end
    end
endmodule

//--- test/dpsf_block_tb.sv
// self-checking bench for the memory block in ram and fifo operation
// assumes one 100 MHz clock; inputs change by non-blocking assignment at the rising edge or 1 ns after it
module dpsf_block_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, fm = 1'b0, sel = 1'b1, we = 1'b0, re = 1'b0, iwe = 1'b0, stall = 1'b0;
    logic rdy, vld, emp, ful, aef, aff, dr;
    logic [2:0] wm = 3'h0, rm = 3'h0;
    logic [11:0] wa = 12'h000, ra = 12'h000;
    logic [17:0] wd = 18'h00000, rdat, got;
    logic [12:0] dep = 13'h0004, ael = 13'h0001, afl = 13'h0003, cnt;
    logic [8:0] irow = 9'h000, idat = 9'h000;
    logic [7:0] gc;
    int error_cnt = 0, n_tests = 0;
    always #5 clk = ~clk;
    dpsf_block dpsf_block_inst (.core_clk_i(clk), .reset_i(rst), .fifo_mode_i(fm), .wr_mode_i(wm),
        .rd_mode_i(rm), .blk_sel_i(sel), .wr_en_i(we), .wr_addr_i(wa), .wr_data_i(wd), .rd_en_i(re),
        .rd_addr_i(ra), .rd_ready_o(rdy), .rd_valid_o(vld), .rd_data_ready_i(dr), .rd_data_o(rdat),
        .fifo_depth_i(dep), .ae_level_i(ael), .af_level_i(afl), .empty_o(emp), .full_o(ful),
        .almost_empty_flag_o(aef), .almost_full_flag_o(aff), .fill_count_o(cnt), .init_we_i(iwe),
        .init_row_i(irow), .init_data_i(idat));
    dpsf_consumer dpsf_consumer_inst (.core_clk_i(clk), .reset_i(rst), .stall_i(stall), .valid_i(vld),
        .data_i(rdat), .ready_o(dr), .got_data_o(got), .got_cnt_o(gc));
    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [17:0] d);
        @(posedge clk);
        wa <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic rd_pulse(input logic [11:0] a);
        @(posedge clk);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
    endtask
    // waits a bounded time for the consumer to take one more word
    task automatic pull(input logic [17:0] exp);
        logic [7:0] c0;
        c0 = gc;
        for (int i = 0; i < 20 && gc === c0; i++) begin
            @(posedge clk);
            #1;
        end
        chk("word arrived", {10'h000, gc}, {10'h000, c0 + 8'h01});
        chk("read word", got, exp);
    endtask
    task automatic flags(input int n);
        chk("count", {5'h00, cnt}, 18'(n));
        chk("empty", {17'h0, emp}, 18'(n == 0));
        chk("full", {17'h0, ful}, 18'(n >= 4));
        chk("almost empty", {17'h0, aef}, 18'(n <= 1));
        chk("almost full", {17'h0, aff}, 18'(n >= 3));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        flags(0);
        chk("valid at reset", {17'h0, vld}, 18'h00000);
        rst <= 1'b0;
        // x18 write seen as two x9 rows
        wm <= dpsf_pkg::DPSF_X18;
        rm <= dpsf_pkg::DPSF_X9;
        wr(12'h003, 18'h2A5F3);
        rd_pulse(12'h006);
        pull(18'h001F3);
        rd_pulse(12'h007);
        pull(18'h00152);
        // x4 write read back one bit at a time
        wm <= dpsf_pkg::DPSF_X4;
        rm <= dpsf_pkg::DPSF_X1;
        wr(12'h000, 18'h0000A);
        for (int b = 0; b < 4; b++) begin
            rd_pulse(12'(b));
            pull(18'((4'hA >> b) & 4'h1));
        end
        // x2 write into the same row, read back as a nibble and as a pair
        wm <= dpsf_pkg::DPSF_X2;
        rm <= dpsf_pkg::DPSF_X4;
        wr(12'h001, 18'h00001);
        rd_pulse(12'h000);
        pull(18'h00006);
        rm <= dpsf_pkg::DPSF_X2;
        rd_pulse(12'h001);
        pull(18'h00001);
        // test-port load, then a deselected write must leave it alone
        wm <= dpsf_pkg::DPSF_X9;
        rm <= dpsf_pkg::DPSF_X9;
        @(posedge clk);
        irow <= 9'h014;
        idat <= 9'h0C3;
        iwe <= 1'b1;
        @(posedge clk);
        iwe <= 1'b0;
        sel <= 1'b0;
        wr(12'h014, 18'h001FF);
        sel <= 1'b1;
        rd_pulse(12'h014);
        pull(18'h000C3);
        // fifo of depth 4, x18; the fifth write must be dropped
        fm <= 1'b1;
        wm <= dpsf_pkg::DPSF_X18;
        for (int i = 0; i < 5; i++) begin
            wr(12'h000, 18'h10000 + 18'(i));
            flags(i < 4 ? i + 1 : 4);
        end
        // fill the output buffer while the consumer stalls
        stall <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_pulse(12'h000);
            flags(3 - i);
        end
        chk("buffer full", {17'h0, rdy}, 18'h00000);
        chk("valid held", {17'h0, vld}, 18'h00001);
        rd_pulse(12'h000);
        flags(0);
        stall <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pull(18'h10000 + 18'(i));
        end
        repeat (6) @(posedge clk);
        #1;
        chk("no extra word", {10'h000, gc}, 18'h0000D);
        finish_test();
    end
endmodule
